// [common/gafu_adc_if.sv]
`timescale 1ns/100ps
// carries the analog channel between the register side and the monitor
interface gafu_adc_if;
  logic [9:0] thr;    // change threshold
  logic [9:0] value;  // latest converted value
  logic report;       // one-cycle pulse: value moved past threshold
  modport mon (input thr, output value, output report);
  modport ctl (output thr, input value, input report);
endinterface : gafu_adc_if

// [common/gafu_pkg.sv]
package gafu_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ADC_RATE_HZ = 50;
  localparam int unsigned ADC_PERIOD_CYC = CLK_HZ / ADC_RATE_HZ;
  localparam int unsigned DEB_TICK_US = 1000;
  localparam int unsigned DEB_TICK_CYC = (CLK_HZ / 1_000_000) * DEB_TICK_US;
  localparam int unsigned DEB_TICKS = 20;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int NPIN = 16;
  localparam int NLOW = 8;
  localparam int NSRC = 9;
  localparam int ADC_W = 10;
  localparam int ST_W = 4;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_ID = 12'h000;
  localparam logic [11:0] OFS_FSEL0 = 12'h004;
  localparam logic [11:0] OFS_FSEL1 = 12'h008;
  localparam logic [11:0] OFS_DIR = 12'h00c;
  localparam logic [11:0] OFS_ODR = 12'h010;
  localparam logic [11:0] OFS_OUT = 12'h014;
  localparam logic [11:0] OFS_PIN = 12'h018;
  localparam logic [11:0] OFS_NTF = 12'h01c;
  localparam logic [11:0] OFS_THR = 12'h020;
  localparam logic [11:0] OFS_ADC = 12'h024;
  localparam logic [11:0] OFS_STAT = 12'h028;
  localparam logic [11:0] OFS_MASK = 12'h02c;
  localparam logic [11:0] OFS_CTRL = 12'h030;
  localparam logic [11:0] OFS_BTN = 12'h034;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [63:0] FSEL_RST = 64'h0000_0000_0000_0000;
  localparam logic [15:0] PIN16_RST = 16'h0000;
  localparam logic [9:0] THR_RST = 10'h010;
  localparam logic [3:0] ST_RST = 4'h0;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ST_PIN = 0;
  localparam int ST_ADC = 1;
  localparam int ST_BTN = 2;
  localparam int ST_CAPT = 3;
  localparam int CT_PLAY_SIL = 0;
  localparam int CT_SELFPW = 1;
  localparam int FSEL_STRIDE = 8;
  // ------------------------------------------------------------
  // function select codes for the eight low pins
  // ------------------------------------------------------------
  localparam logic [4:0] FN_GPIO = 5'h00;
  localparam logic [4:0] FN_BTN_FIRST = 5'h01;
  localparam logic [4:0] FN_CAPT = 5'h09;
  localparam logic [4:0] FN_OUT_FIRST = 5'h0a;
  localparam logic [4:0] FN_OUT_LAST = 5'h11;
endpackage : gafu_pkg

// [hw/gafu_adc_mon.sv]
`timescale 1ns/100ps
module gafu_adc_mon
  import gafu_pkg::*;
#(
  parameter int unsigned PERIOD = ADC_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [9:0] adc_result,
  input wire logic adc_done,
  output logic convert_ff,
  gafu_adc_if.mon a
);
  // ------------------------------------------------------------
  // sample rate timer: one conversion request per period
  // ------------------------------------------------------------
  localparam int CW = $clog2(PERIOD + 1);
  logic [CW-1:0] cnt_ff;     // period counter
  logic [9:0] value_ff;      // latest result
  logic [9:0] last_ff;       // last value that was reported
  logic report_ff;           // report pulse
  logic [9:0] diff;          // distance from the last report

  // free-running timer; the analog macro answers with adc_done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      convert_ff <= 1'b0;
    end else begin
      convert_ff <= (cnt_ff == CW'(PERIOD - 1));
      cnt_ff <= (cnt_ff == CW'(PERIOD - 1)) ? '0 : cnt_ff + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // change detector against the last reported value
  // ------------------------------------------------------------
  always_comb begin
    diff = (adc_result > last_ff) ? adc_result - last_ff
                                  : last_ff - adc_result;
  end

  // only a report moves the reference, so slow drift still reports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= 10'h000;
      last_ff <= 10'h000;
      report_ff <= 1'b0;
    end else begin
      report_ff <= adc_done && (diff > a.thr);
      if (adc_done) begin
        value_ff <= adc_result;
        if (diff > a.thr) begin
          last_ff <= adc_result;
        end
      end
    end
  end

  assign a.value = value_ff;
  assign a.report = report_ff;

  a_adc_report: assert property (
    @(posedge pclk) disable iff (!presetn)
    (adc_done && diff > a.thr) |=> report_ff && last_ff == value_ff)
    else $error("large analog change not reported");
  a_adc_rate: assert property (
    @(posedge pclk) disable iff (!presetn)
    convert_ff |=> !convert_ff [*8])
    else $error("conversion requests too close together");
endmodule : gafu_adc_mon

// [hw/gafu_debounce.sv]
`timescale 1ns/100ps
module gafu_debounce
  import gafu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic raw,
  output logic stable_ff
);
  // ------------------------------------------------------------
  // stability counter, counted in sampling ticks
  // ------------------------------------------------------------
  logic [4:0] cnt_ff; // ticks the raw level has differed

  // any bounce back to the accepted level restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 5'h00;
      stable_ff <= 1'b0;
    end else if (raw == stable_ff) begin
      cnt_ff <= 5'h00;
    end else if (tick) begin
      if (cnt_ff == 5'(DEB_TICKS - 1)) begin
        stable_ff <= raw;
        cnt_ff <= 5'h00;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
  end

  a_deb_on_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    (stable_ff != $past(stable_ff)) |-> $past(tick) && $past(cnt_ff) ==
      5'(DEB_TICKS - 1))
    else $error("debounced level moved without a full interval");
endmodule : gafu_debounce

// [hw/gafu_top.sv]
`timescale 1ns/100ps
// Functional notes
// - analog pin sampled 50/s, 10-bit result
// - analog value polled or reported past threshold
// - any function on any low pin
// - outputs on several pins, open-drain or push-pull
// - alternate pins driven, still readable
// - eight media buttons plus capture toggle
// - buttons active low, report press and release
// - capture state flips on debounced release
// - sleep indicators follow USB suspend
// - suspend when self-powered and link lost
// - idle indicators when audio and serial idle
// - capture indicators follow capture mute state
// - playback indicators follow host mute command
// - host sets general output levels
// - host polls pins and analog value
// - notify on change of selected pins
// - all sixteen pins monitored
// - every access handled independently, no session
module gafu_top
  import gafu_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h0000_5a11, // arbitrary value
  parameter int unsigned TICK_CYC = DEB_TICK_CYC,
  parameter int unsigned ADC_CYC = ADC_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] gpio_in,
  output logic [15:0] gpio_out,
  output logic [15:0] gpio_oe_n,
  input wire logic usb_connected,
  input wire logic usb_bus_active,
  input wire logic audio_idle,
  input wire logic serial_idle,
  input wire logic [9:0] adc_result,
  input wire logic adc_done,
  output logic adc_convert,
  output logic hid_report_strobe,
  output logic [7:0] hid_buttons,
  output logic irq
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [19:0] s1_ff;      // first stage, read only by s2_ff
  logic [19:0] s2_ff;      // synchronised pins and status lines
  logic [15:0] pin_s;      // pad levels, all sixteen pins
  logic conn_s;
  logic act_s;
  logic aidle_s;
  logic sidle_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 20'h0_0000;
      s2_ff <= 20'h0_0000;
    end else begin
      s1_ff <= {serial_idle, audio_idle, usb_bus_active, usb_connected,
                gpio_in};
      s2_ff <= s1_ff;
    end
  end
  assign pin_s = s2_ff[15:0];
  assign conn_s = s2_ff[16];
  assign act_s = s2_ff[17];
  assign aidle_s = s2_ff[18];
  assign sidle_s = s2_ff[19];

  // ------------------------------------------------------------
  // registers written by software
  // ------------------------------------------------------------
  logic [63:0] fsel_ff;    // 5-bit function code per low pin
  logic [15:0] dir_ff;     // general pin drives when set
  logic [15:0] odr_ff;     // open-drain select per pin
  logic [15:0] out_ff;     // general output levels
  logic [15:0] ntf_ff;     // pins that raise change notices
  logic [9:0] thr_ff;      // analog report threshold
  logic [3:0] mask_ff;     // interrupt enables
  logic [1:0] ctrl_ff;     // playback mute, self-powered
  logic [3:0] status_ff;   // sticky events
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;
  logic wr_en;             // write takes effect this edge
  logic [3:0] events;      // status set terms

  // access phase always answers in its first cycle
  assign wr_en = psel && penable && pready_ff && pwrite;

  // register writes; each access stands alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_ff <= FSEL_RST;
      dir_ff <= PIN16_RST;
      odr_ff <= PIN16_RST;
      out_ff <= PIN16_RST;
      ntf_ff <= PIN16_RST;
      thr_ff <= THR_RST;
      mask_ff <= ST_RST;
      ctrl_ff <= CTRL_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_FSEL0: fsel_ff[31:0] <= pwdata;
        OFS_FSEL1: fsel_ff[63:32] <= pwdata;
        OFS_DIR: dir_ff <= pwdata[15:0];
        OFS_ODR: odr_ff <= pwdata[15:0];
        OFS_OUT: out_ff <= pwdata[15:0];
        OFS_NTF: ntf_ff <= pwdata[15:0];
        OFS_THR: thr_ff <= pwdata[9:0];
        OFS_MASK: mask_ff <= pwdata[3:0];
        OFS_CTRL: ctrl_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= ST_RST;
    end else begin
      status_ff <= (status_ff & ~((wr_en && paddr == OFS_STAT) ?
                   pwdata[3:0] : 4'h0)) | events;
    end
  end

  // ------------------------------------------------------------
  // APB slave: read mux and one-cycle answer
  // ------------------------------------------------------------
  gafu_adc_if adc_bus ();
  logic [8:0] src_db;      // debounced sources, 8 = capture
  logic capt_state_ff;     // capture mute state

  // read data is picked in the setup cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    unique case (paddr)
      OFS_ID: nxt_prdata = ID_VALUE;
      OFS_FSEL0: nxt_prdata = fsel_ff[31:0];
      OFS_FSEL1: nxt_prdata = fsel_ff[63:32];
      OFS_DIR: nxt_prdata[15:0] = dir_ff;
      OFS_ODR: nxt_prdata[15:0] = odr_ff;
      OFS_OUT: nxt_prdata[15:0] = out_ff;
      OFS_PIN: nxt_prdata[15:0] = pin_s;
      OFS_NTF: nxt_prdata[15:0] = ntf_ff;
      OFS_THR: nxt_prdata[9:0] = thr_ff;
      OFS_ADC: nxt_prdata[9:0] = adc_bus.value;
      OFS_STAT: nxt_prdata[3:0] = status_ff;
      OFS_MASK: nxt_prdata[3:0] = mask_ff;
      OFS_CTRL: nxt_prdata[1:0] = ctrl_ff;
      OFS_BTN: nxt_prdata[9:0] = {capt_state_ff, src_db};
      default: nxt_slverr = 1'b1;
    endcase
  end

  // pready rises in the first access cycle and falls after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
      if (psel && !penable) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
        pslverr_ff <= nxt_slverr;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ------------------------------------------------------------
  // analog channel
  // ------------------------------------------------------------
  assign adc_bus.thr = thr_ff;

  gafu_adc_mon #(
    .PERIOD(ADC_CYC)
  ) u_adc (
    .pclk(pclk),
    .presetn(presetn),
    .adc_result(adc_result),
    .adc_done(adc_done),
    .convert_ff(adc_convert),
    .a(adc_bus.mon)
  );

  // ------------------------------------------------------------
  // debounce tick and input functions
  // ------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYC + 1);
  logic [TW-1:0] tick_cnt_ff; // sampling tick divider
  logic tick_ff;
  logic [8:0] src_raw;        // pressed when any mapped pin is low

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (tick_cnt_ff == TW'(TICK_CYC - 1));
      tick_cnt_ff <= (tick_cnt_ff == TW'(TICK_CYC - 1)) ? '0
                     : tick_cnt_ff + 1'b1;
    end
  end

  // codes 1..8 are media buttons, code 9 the capture toggle
  for (genvar f = 0; f < NSRC; f++) begin : g_src
    logic [7:0] hit;
    for (genvar p = 0; p < NLOW; p++) begin : g_hit
      assign hit[p] = fsel_ff[p*FSEL_STRIDE +: 5] ==
                      5'(FN_BTN_FIRST + 5'(f));
    end
    assign src_raw[f] = |(hit & ~pin_s[7:0]);
    gafu_debounce u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_ff),
      .raw(src_raw[f]),
      .stable_ff(src_db[f])
    );
  end

  // ------------------------------------------------------------
  // media report and capture toggle
  // ------------------------------------------------------------
  logic [8:0] src_prev_ff;    // last debounced sources
  logic hid_strobe_ff;
  logic [7:0] hid_buttons_ff;
  logic btn_event;
  logic capt_event;

  assign btn_event = src_db[7:0] != src_prev_ff[7:0];
  // pressed to released is the low-to-high edge of the input
  assign capt_event = src_prev_ff[8] && !src_db[8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_ff <= 9'h000;
      hid_strobe_ff <= 1'b0;
      hid_buttons_ff <= 8'h00;
      capt_state_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_db;
      hid_strobe_ff <= btn_event;
      if (btn_event) begin
        hid_buttons_ff <= src_db[7:0];
      end
      if (capt_event) begin
        capt_state_ff <= !capt_state_ff;
      end
    end
  end
  assign hid_report_strobe = hid_strobe_ff;
  assign hid_buttons = hid_buttons_ff;

  // ------------------------------------------------------------
  // power and mute indicator levels
  // ------------------------------------------------------------
  logic susp_ff;           // in USB suspend
  logic idle_ff;           // in low-power mode
  logic [7:0] alt_lvl;     // output function levels by code-10

  // bus-powered builds never suspend
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      susp_ff <= ctrl_ff[CT_SELFPW] && (!conn_s || !act_s);
      idle_ff <= aidle_s && sidle_s;
    end
  end
  assign alt_lvl = {!ctrl_ff[CT_PLAY_SIL], ctrl_ff[CT_PLAY_SIL],
                    !capt_state_ff, capt_state_ff,
                    !idle_ff, idle_ff,
                    !susp_ff, susp_ff};

  // ------------------------------------------------------------
  // pad drivers
  // ------------------------------------------------------------
  logic [15:0] nxt_out;
  logic [15:0] nxt_oe_n;
  logic [15:0] gpio_out_ff;
  logic [15:0] gpio_oe_n_ff;

  for (genvar p = 0; p < NPIN; p++) begin : g_pad
    logic alt_out;
    logic alt_in;
    logic lvl;
    logic drv;
    if (p < NLOW) begin : g_low
      logic [4:0] code;
      logic [4:0] oidx;
      assign code = fsel_ff[p*FSEL_STRIDE +: 5];
      assign oidx = code - FN_OUT_FIRST;
      assign alt_out = code >= FN_OUT_FIRST && code <= FN_OUT_LAST;
      assign alt_in = code != FN_GPIO && code <= FN_CAPT;
      assign lvl = alt_out ? alt_lvl[oidx[2:0]] : out_ff[p];
    end else begin : g_high
      assign alt_out = 1'b0;
      assign alt_in = 1'b0;
      assign lvl = out_ff[p];
    end
    // input functions never drive; open drain only pulls low
    assign drv = alt_out || (!alt_in && dir_ff[p]);
    assign nxt_out[p] = lvl;
    assign nxt_oe_n[p] = !(drv && (!odr_ff[p] || !lvl));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out_ff <= PIN16_RST;
      gpio_oe_n_ff <= 16'hffff;
    end else begin
      gpio_out_ff <= nxt_out;
      gpio_oe_n_ff <= nxt_oe_n;
    end
  end
  assign gpio_out = gpio_out_ff;
  assign gpio_oe_n = gpio_oe_n_ff;

  // ------------------------------------------------------------
  // change notices and interrupt
  // ------------------------------------------------------------
  logic [15:0] pin_prev_ff;
  logic pin_event;
  logic irq_ff;

  // alternate pins are watched too, since the pad is sampled
  assign pin_event = |((pin_s ^ pin_prev_ff) & ntf_ff);
  assign events = {capt_event, btn_event, adc_bus.report, pin_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_ff <= PIN16_RST;
      irq_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_s;
      irq_ff <= |(status_ff & mask_ff);
    end
  end
  assign irq = irq_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_pin_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFS_PIN)
      |=> prdata[15:0] == $past(pin_s) && pready)
    else $error("pin read does not return pad levels");
  a_pin_notify: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|((pin_s ^ pin_prev_ff) & ntf_ff)) |=> status_ff[ST_PIN])
    else $error("selected pin change not flagged");
  a_hid_edges: assert property (
    @(posedge pclk) disable iff (!presetn)
    (src_db[7:0] != src_prev_ff[7:0])
      |=> hid_report_strobe && hid_buttons == $past(src_db[7:0]))
    else $error("button edge without report");
  a_capt_flip: assert property (
    @(posedge pclk) disable iff (!presetn)
    (src_prev_ff[8] && !src_db[8])
      |=> capt_state_ff != $past(capt_state_ff))
    else $error("capture state did not flip on release");
  a_susp_enter: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_ff[CT_SELFPW] && !conn_s) ##1 ctrl_ff[CT_SELFPW] |-> susp_ff)
    else $error("no suspend after link loss");
  a_idle_pair: assert property (
    @(posedge pclk) disable iff (!presetn)
    (aidle_s && sidle_s) |=> alt_lvl[2] && !alt_lvl[3])
    else $error("idle indicators wrong");
  a_gpio_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dir_ff[15] && !odr_ff[15])
      |=> !gpio_oe_n[15] && gpio_out[15] == $past(out_ff[15]))
    else $error("general output not driven");
  a_odrain_rel: assert property (
    @(posedge pclk) disable iff (!presetn)
    (odr_ff[15] && out_ff[15]) |=> gpio_oe_n[15])
    else $error("open-drain pin drives high");
endmodule : gafu_top

// [sim/gafu_partner.sv]
`timescale 1ns/100ps
// converter on the far side: answers each request, alternately fast and slow
module gafu_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_convert,
  input wire logic [9:0] level,
  output logic [9:0] adc_result,
  output logic adc_done
);
  int cnt;
  bit slow;
  // result bus toggles outside the answer cycle so stale data never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      slow <= 0;
      adc_done <= 1'b0;
      adc_result <= 10'h3ff;
    end else begin
      adc_done <= 1'b0;
      adc_result <= ~adc_result;
      if (adc_convert) begin
        cnt <= slow ? 9 : 2;
      end else if (cnt == 1) begin
        cnt <= 0;
        adc_done <= 1'b1;
        adc_result <= level;
        slow <= !slow;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : gafu_partner

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
  import gafu_pkg::*;
  // ------------------------------------------------------------
  // stimulus, model state and counters
  // ------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, irq, adc_convert, adc_done, hid_report_strobe;
  logic [15:0] gpio_in = 16'hffff, gpio_out, gpio_oe_n, rnd;
  logic conn = 1, act = 1, aidle = 0, sidle = 0;
  logic [9:0] level = 0, adc_result;
  logic [7:0] hid_buttons;
  int err_count = 0, n_checks = 0, cyc = 0, exp_cap = 0, hid_q[$];
  always #12.5 pclk = ~pclk;
  gafu_top #(.TICK_CYC(4), .ADC_CYC(20)) u_gafu_top (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .usb_connected(conn), .usb_bus_active(act),
    .audio_idle(aidle), .serial_idle(sidle), .adc_result(adc_result),
    .adc_done(adc_done), .adc_convert(adc_convert),
    .hid_report_strobe(hid_report_strobe), .hid_buttons(hid_buttons),
    .irq(irq));
  gafu_partner u_gafu_partner (.pclk(pclk), .presetn(presetn),
    .adc_convert(adc_convert), .level(level), .adc_result(adc_result),
    .adc_done(adc_done));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // apb master: held until pready is seen at a rising edge, data taken at
  // that same edge; only the bench timeout ends a slave that never answers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, e,
                      input string s);
    apb(1'b0, a, 0);
    chk(rd & m, e, s);
  endtask : rchk
  // bounded wait for one debounced report
  task automatic wait_hid();
    int i;
    i = 0;
    do begin
      @(negedge pclk);
      i++;
    end while (hid_report_strobe !== 1'b1 && i < 300);
    chk(i < 300, 1, "no hid report");
  endtask : wait_hid
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle
  // timeout keeps a hung wait from stalling the run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(13611));
    settle(2);
    presetn <= 1'b1;
    rchk(OFS_THR, 32'h0000_03ff, 32'h0000_0010, "thr reset");
    apb(1'b1, OFS_ID, 0);
    rchk(OFS_ID, 32'hffff_ffff, 32'h0000_5a11, "id changed");
    apb(1'b0, 12'h0fc, 0);
    chk(er, 1, "no error on hole");
    apb(1'b1, OFS_FSEL0, 32'h0901_1110);
    apb(1'b1, OFS_FSEL1, 32'h000c_0a0e);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    settle(4);
    chk({gpio_out[1:0], gpio_oe_n[1:0]}, 4'b0100, "playback ind");
    // random pad levels, buttons kept released
    rnd = 16'($urandom());
    gpio_in <= {rnd[15:8], 8'hff};
    settle(4);
    rchk(OFS_PIN, 32'h0000_ffff, {16'h0, rnd[15:8], 8'hff}, "pins");
    apb(1'b1, OFS_NTF, 32'h0000_0100);
    gpio_in[8] <= ~rnd[8];
    settle(4);
    rchk(OFS_STAT, 32'h0000_0001, 32'h0000_0001, "notify");
    apb(1'b1, OFS_DIR, 32'h0000_8000);
    apb(1'b1, OFS_OUT, 32'h0000_8000);
    settle(2);
    chk({gpio_out[15], gpio_oe_n[15]}, 2'b10, "gpio out");
    apb(1'b1, OFS_MASK, 32'h0000_0004);
    apb(1'b1, OFS_STAT, 32'h0000_000f);
    gpio_in[2] <= 1'b0;
    hid_q.push_back(1); // play/pause is bit 0 of the report
    wait_hid();
    chk(hid_buttons, hid_q.pop_front(), "press");
    settle(2);
    chk(irq, 1, "irq on press");
    apb(1'b1, OFS_STAT, 32'h0000_0004);
    settle(2);
    chk(irq, 0, "irq after clear");
    gpio_in[2] <= 1'b1;
    hid_q.push_back(0); // release empties the report
    wait_hid();
    chk(hid_buttons, hid_q.pop_front(), "release");
    apb(1'b1, OFS_MASK, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      gpio_in[3] <= 1'b0;
      settle(150);
      chk(gpio_out[4], exp_cap, "no toggle on press");
      gpio_in[3] <= 1'b1;
      exp_cap = 1 - exp_cap;
      settle(150);
      chk(gpio_out[4], exp_cap, "capture ind");
    end
    rchk(OFS_STAT, 32'h0000_0008, 32'h0000_0008, "capture stat");
    chk(irq, 0, "masked irq");
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    conn <= 1'b0;
    settle(6);
    chk(gpio_out[5], 1, "sleep ind");
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    settle(6);
    chk(gpio_out[5], 0, "bus powered");
    {aidle, sidle} <= 2'b11;
    settle(6);
    chk(gpio_out[6], 1, "idle ind");
    sidle <= 1'b0;
    settle(6);
    chk(gpio_out[6], 0, "busy");
    level <= 10'h064;
    settle(60);
    rchk(OFS_ADC, 32'h0000_03ff, 32'h0000_0064, "adc value");
    apb(1'b1, OFS_STAT, 32'h0000_000f);
    level <= 10'h06e;
    settle(60);
    rchk(OFS_STAT, 32'h0000_0002, 32'h0000_0000, "below thr");
    level <= 10'h080;
    settle(60);
    rchk(OFS_STAT, 32'h0000_0002, 32'h0000_0002, "past thr");
    test_done();
  end
endmodule : tb
